// ==== rtl/csc_top.sv ====
// Operation
// - One clock; input register, one internal pipeline register, output register.
// - Each converted triple appears three cycles after its input triple.
// - A new triple is taken every cycle; one result leaves every cycle.
// - Products and sums carry ten fraction bits before the result forms.
// - Each output component is rounded to 8 bits, not truncated.
// - RGB to offset luma/chroma with the 0.257 family of coefficients plus 16/128.
// - Offset luma/chroma back to RGB after removing 16 and 128 offsets.
// - RGB to plain luma/chroma with the 0.299 family, no offsets.
// - Plain luma/chroma back to RGB with the 1.140 family of coefficients.
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_top import csc_pkg::*; #(
	parameter csc_mode_t MODE = csc_rgb_to_luma_chroma_offset
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Upstream pixel stream
	input wire logic in_valid,
	input wire csc_pix_t in_data,
	output logic in_ready,
	// Downstream pixel stream
	output logic out_valid,
	output csc_pix_t out_data,
	input wire logic out_ready
);

	// Coefficients for the chosen conversion
	localparam csc_mat_t COEF = (MODE == csc_luma_chroma_offset_to_rgb) ? `CSC_MAT_OFS_DEC :
		(MODE == csc_rgb_to_luma_chroma_plain) ? `CSC_MAT_PLAIN_ENC :
		(MODE == csc_luma_chroma_plain_to_rgb) ? `CSC_MAT_PLAIN_DEC :
		`CSC_MAT_OFS_ENC;

	// Offsets removed from inputs and added to outputs
	localparam csc_ofs_t IN_OFS = (MODE == csc_luma_chroma_offset_to_rgb) ?
		{`CSC_LUMA_OFS, `CSC_CHROMA_OFS, `CSC_CHROMA_OFS} : '0;
	localparam csc_ofs_t OUT_OFS = (MODE == csc_rgb_to_luma_chroma_offset) ?
		{`CSC_LUMA_OFS, `CSC_CHROMA_OFS, `CSC_CHROMA_OFS} : '0;

	// Components carried as two's complement
	localparam logic [0:2] IN_SGN = (MODE == csc_luma_chroma_plain_to_rgb) ? 3'h3 : 3'h0;
	localparam logic [0:2] OUT_SGN = (MODE == csc_rgb_to_luma_chroma_plain) ? 3'h3 : 3'h0;

	csc_buf_if bus ();

	logic en;
	logic s1_valid;
	csc_pix_t s1_pix;
	logic signed [9:0] x [0:2];
	csc_acc_t next_acc;
	logic s2_valid;
	csc_acc_t acc;
	logic signed [25:0] rnd [0:2];
	logic signed [15:0] q [0:2];
	csc_pix_t next_out;

	// Whole pipeline moves only while the buffer can take a word
	// A stall freezes the input and internal registers at once, so no word is dropped or doubled
	assign en = bus.push_ready;

	// Input register; RGB taken as already gamma corrected
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_valid <= 1'b0;
			s1_pix <= `CSC_PIX_RST;
		end else if (en) begin
			s1_valid <= in_valid;
			s1_pix <= in_data;
		end
	end

	// Offset removal and fixed-point products
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			x[k] = $signed(IN_SGN[k] ? {{2{s1_pix[k][7]}}, s1_pix[k]} : {2'h0, s1_pix[k]})
				- $signed(IN_OFS[k]);
		end
		for (int r = 0; r < 3; r++) begin
			next_acc[r] = 26'($signed(COEF[3 * r])) * 26'(x[0])
				+ 26'($signed(COEF[3 * r + 1])) * 26'(x[1])
				+ 26'($signed(COEF[3 * r + 2])) * 26'(x[2]);
		end
	end

	// Internal pipeline register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s2_valid <= 1'b0;
			acc <= '0;
		end else if (en) begin
			s2_valid <= s1_valid;
			acc <= next_acc;
		end
	end

	// Output offset, round half up, saturate
	always_comb begin
		next_out = `CSC_PIX_RST;
		for (int k = 0; k < 3; k++) begin
			rnd[k] = $signed(acc[k]) + $signed({6'h00, OUT_OFS[k], 10'h000})
				+ `CSC_ROUND_HALF;
			q[k] = rnd[k][25:`CSC_FRAC_BITS];
			if (OUT_SGN[k]) begin
				if (q[k] > `CSC_SMAX) next_out[k] = 8'(`CSC_SMAX);
				else if (q[k] < `CSC_SMIN) next_out[k] = 8'(`CSC_SMIN);
				else next_out[k] = q[k][7:0];
			end else begin
				if (q[k] > `CSC_UMAX) next_out[k] = 8'(`CSC_UMAX);
				else if (q[k] < `CSC_UMIN) next_out[k] = 8'(`CSC_UMIN);
				else next_out[k] = q[k][7:0];
			end
		end
	end

	// Buffer entries act as the output register
	assign bus.push_valid = s2_valid;
	assign bus.push_data = next_out;
	assign bus.pop_ready = out_ready;

	// Two-entry buffer; its head entry is the output register
	// Second entry catches the word already in flight when the receiver stalls
	csc_skid u_skid (
		.clk_sys(clk_sys),
		.rst(rst),
		.bus(bus)
	);

	// Ports straight from buffer flip-flops
	assign in_ready = bus.push_ready;
	assign out_valid = bus.pop_valid;
	assign out_data = bus.pop_data;

	// Known points for checking
	localparam csc_pix_t PIX_WHITE = 24'hffffff;
	localparam csc_pix_t PIX_LUMA_TOP = 24'heb8080;
	localparam csc_pix_t PIX_G_ONE = 24'h000100;
	localparam csc_pix_t PIX_G_ONE_OUT = 24'h118080;
	localparam csc_pix_t PIX_B_FULL = 24'h0000ff;
	localparam csc_pix_t PIX_B_FULL_OUT = 24'h296ef0;
	localparam csc_pix_t PIX_LOW = 24'h101010;
	localparam csc_pix_t PIX_LOW_OUT = 24'h008700;
	localparam csc_pix_t PIX_Y_ONLY = 24'hff0000;
	localparam csc_pix_t PIX_BLK = 24'h000000;
	localparam csc_pix_t PIX_BLK_ENC = 24'h108080;
	localparam csc_pix_t PIX_BLK_DEC = 24'h008800;
	localparam csc_pix_t PIX_B_PLAIN = 24'h1d6fe7;
	localparam csc_pix_t PIX_R_PLAIN = 24'h4cda7f;
	localparam csc_pix_t PIX_MID = 24'h80807f;
	localparam csc_pix_t PIX_MID_OUT = 24'hff69ff;
	localparam bit IS_OFS_ENC = (MODE == csc_rgb_to_luma_chroma_offset);
	localparam bit IS_OFS_DEC = (MODE == csc_luma_chroma_offset_to_rgb);
	localparam bit IS_PLAIN_ENC = (MODE == csc_rgb_to_luma_chroma_plain);
	localparam bit IS_PLAIN_DEC = (MODE == csc_luma_chroma_plain_to_rgb);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// A given input leaves as a given output, streaming unstalled
	property p_map(bit act, csc_pix_t pin, csc_pix_t pout);
		act && in_valid && in_ready && out_ready && in_data == pin
			##1 (in_ready && out_ready) [*2]
			|=> out_valid && out_data == pout;
	endproperty

	chk_input_capture: assert property (in_ready |=> s1_pix == $past(in_data))
		else $error("input register missed a sample");
	chk_pipe_advance: assert property (in_ready && s1_valid |=> s2_valid)
		else $error("pipeline register did not advance");
	chk_latency_three: assert property ((in_valid && in_ready) ##1 in_ready [*2]
		|=> out_valid)
		else $error("result not present three cycles after input");
	chk_ready_return: assert property (out_ready |=> in_ready)
		else $error("input stalled while receiver was ready");
	chk_stall_hold: assert property (!in_ready |=> $stable(acc) && $stable(s2_valid))
		else $error("pipeline moved during a stall");
	chk_precision_ten: assert property (p_map(IS_OFS_ENC, PIX_B_FULL, PIX_B_FULL_OUT))
		else $error("fixed-point result off for full blue");
	chk_round_half: assert property (p_map(IS_OFS_ENC, PIX_G_ONE, PIX_G_ONE_OUT))
		else $error("result truncated instead of rounded");
	chk_offset_encode: assert property (p_map(IS_OFS_ENC, PIX_WHITE, PIX_LUMA_TOP))
		else $error("offset encode of white wrong");
	chk_offset_decode: assert property (p_map(IS_OFS_DEC, PIX_LUMA_TOP, PIX_WHITE))
		else $error("offset decode of top luma wrong");
	chk_plain_encode: assert property (p_map(IS_PLAIN_ENC, PIX_WHITE, PIX_Y_ONLY))
		else $error("plain encode of white wrong");
	chk_plain_decode: assert property (p_map(IS_PLAIN_DEC, PIX_Y_ONLY, PIX_WHITE))
		else $error("plain decode of full luma wrong");
	chk_clamp_low: assert property (p_map(IS_OFS_DEC, PIX_LOW, PIX_LOW_OUT))
		else $error("negative result not clamped to zero");

	// Further known points: offsets at black, signed outputs, clamping
	chk_offset_black: assert property (p_map(IS_OFS_ENC, PIX_BLK, PIX_BLK_ENC))
		else $error("offset encode of black wrong");
	chk_decode_black: assert property (p_map(IS_OFS_DEC, PIX_BLK, PIX_BLK_DEC))
		else $error("offset decode of black wrong");
	chk_plain_signed: assert property (p_map(IS_PLAIN_ENC, PIX_B_FULL, PIX_B_PLAIN))
		else $error("plain encode of full blue wrong");
	chk_clamp_signed: assert property (p_map(IS_PLAIN_ENC, PIX_Y_ONLY, PIX_R_PLAIN))
		else $error("signed result not clamped to its range");
	chk_clamp_high: assert property (p_map(IS_PLAIN_DEC, PIX_MID, PIX_MID_OUT))
		else $error("result above full scale not clamped");

	// Stalls hold every stage; bubbles never reach the receiver
	chk_out_hold: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_data))
		else $error("waiting output word changed or vanished");
	chk_input_hold: assert property (!in_ready |=> $stable(s1_pix) && $stable(s1_valid))
		else $error("input register moved during a stall");
	chk_bubble_drop: assert property (!s2_valid && !out_valid |=> !out_valid)
		else $error("empty slot showed up as a word");

	// Main scenarios
	cv_receiver_stall: cover property (out_valid && !out_ready ##1 !in_ready);
	cv_full_stream: cover property ((in_valid && in_ready && out_valid && out_ready) [*4]);
	cv_stall_release: cover property (!in_ready ##1 in_ready ##1 in_valid);
	cv_out_gap: cover property (out_valid && out_ready ##1 !out_valid);
	cv_long_stall: cover property (!in_ready [*2]);

endmodule : csc_top

// ==== inc/csc_regs.svh ====
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Fixed-point scaling of coefficients and sums
`define CSC_FRAC_BITS 10
`define CSC_ROUND_HALF 26'sh200

// Offsets of the luma and chroma components
`define CSC_LUMA_OFS 10'h010
`define CSC_CHROMA_OFS 10'h080

// Output ranges for unsigned and signed components
`define CSC_UMAX 16'sh0ff
`define CSC_UMIN 16'sh000
`define CSC_SMAX 16'sh07f
`define CSC_SMIN (-16'sh080)

// Pipeline depth from input to output
`define CSC_LATENCY 3

// Reset value of every pixel register
`define CSC_PIX_RST 24'h000000

// Coefficient matrices, row-major, scaled by two to the tenth
`define CSC_MAT_OFS_ENC {14'sh107, 14'sh204, 14'sh064, 14'sh1c2, -14'sh179, -14'sh049, \
	-14'sh098, -14'sh12a, 14'sh1c2}
`define CSC_MAT_OFS_DEC {14'sh4a8, 14'sh662, 14'sh000, 14'sh4a8, -14'sh341, -14'sh191, \
	14'sh4a8, 14'sh000, 14'sh811}
`define CSC_MAT_PLAIN_ENC {14'sh132, 14'sh259, 14'sh075, -14'sh097, -14'sh128, 14'sh1be, \
	14'sh276, -14'sh20f, -14'sh066}
`define CSC_MAT_PLAIN_DEC {14'sh400, 14'sh000, 14'sh48f, 14'sh400, -14'sh193, -14'sh253, \
	14'sh400, -14'sh821, 14'sh000}

`endif

// ==== inc/csc_pkg.sv ====
package csc_pkg;

	// Conversion selected at build time
	typedef enum logic [3:0] {
		csc_rgb_to_luma_chroma_offset = 4'h1,
		csc_luma_chroma_offset_to_rgb = 4'h2,
		csc_rgb_to_luma_chroma_plain = 4'h4,
		csc_luma_chroma_plain_to_rgb = 4'h8
	} csc_mode_t;

	// Three 8-bit components, component 0 first
	typedef logic [0:2][7:0] csc_pix_t;

	// Nine 14-bit signed coefficients, row-major
	typedef logic [0:8][13:0] csc_mat_t;

	// Per-component input or output offsets
	typedef logic [0:2][9:0] csc_ofs_t;

	// Per-component accumulated sums with ten fraction bits
	typedef logic [0:2][25:0] csc_acc_t;

endpackage : csc_pkg

// ==== inc/csc_buf_if.sv ====
`timescale 1ns/10ps
interface csc_buf_if import csc_pkg::*; ();
	// Filling side
	logic push_valid;
	logic push_ready;
	csc_pix_t push_data;
	// Draining side
	logic pop_valid;
	logic pop_ready;
	csc_pix_t pop_data;

	modport core (
		output push_valid,
		output push_data,
		input push_ready,
		input pop_valid,
		input pop_data,
		output pop_ready
	);

	modport store (
		input push_valid,
		input push_data,
		output push_ready,
		output pop_valid,
		output pop_data,
		input pop_ready
	);
endinterface : csc_buf_if

// ==== rtl/csc_skid.sv ====
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_skid import csc_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Both sides of the buffer
	csc_buf_if.store bus
);

	logic head_valid;
	csc_pix_t head_data;
	logic skid_empty;
	csc_pix_t skid_data;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = bus.push_valid && skid_empty;
	assign pop = head_valid && bus.pop_ready;

	// Head entry, seen by the receiver
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			head_valid <= 1'b0;
			head_data <= `CSC_PIX_RST;
		end else if (push && (!head_valid || pop)) begin
			head_valid <= 1'b1;
			head_data <= bus.push_data;
		end else if (pop && !skid_empty) begin
			head_data <= skid_data;
		end else if (pop) begin
			head_valid <= 1'b0;
		end
	end

	// Second entry, catches the word arriving during a stall
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			skid_empty <= 1'b1;
			skid_data <= `CSC_PIX_RST;
		end else if (push && head_valid && !pop) begin
			skid_empty <= 1'b0;
			skid_data <= bus.push_data;
		end else if (pop) begin
			skid_empty <= 1'b1;
		end
	end

	// All answers straight from flip-flops
	assign bus.push_ready = skid_empty;
	assign bus.pop_valid = head_valid;
	assign bus.pop_data = head_data;

endmodule : csc_skid

// ==== tb/csc_sink.sv ====
`timescale 1ns/10ps
module csc_sink (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Pace select and acceptance
	input wire logic slow,
	output logic out_ready
);
	logic [1:0] cnt;
	// Slow pace accepts one cycle in four; RGB is gamma corrected
	always_ff @(posedge clk_sys) begin
		cnt <= rst ? 2'h0 : cnt + 2'h1;
		out_ready <= rst || !slow || cnt == 2'h3;
	end
endmodule : csc_sink

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top import csc_pkg::*; ;
	localparam csc_mode_t MODES [4] = '{csc_rgb_to_luma_chroma_offset,
		csc_luma_chroma_offset_to_rgb, csc_rgb_to_luma_chroma_plain, csc_luma_chroma_plain_to_rgb};
	localparam int COEF [4][9] = '{'{263, 516, 100, 450, -377, -73, -152, -298, 450},
		'{1192, 1634, 0, 1192, -833, -401, 1192, 0, 2065},
		'{306, 601, 117, -151, -296, 446, 630, -527, -102},
		'{1024, 0, 1167, 1024, -403, -595, 1024, -2081, 0}};
	localparam csc_pix_t PIX [10] = '{24'hffffff, 24'h000000, 24'h0000ff, 24'h000100,
		24'heb8080, 24'h101010, 24'hff0000, 24'h80807f, 24'h12fe34, 24'h7f8081};
	logic clk_sys, rst, in_valid, out_ready, slow;
	csc_pix_t in_data;
	logic [3:0] rdy, ov;
	csc_pix_t od [4];
	csc_pix_t got [4][$];
	int errors, tests_run, cyc, stalls;

	// Free-running clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	csc_sink i_sink (.clk_sys(clk_sys), .rst(rst), .slow(slow), .out_ready(out_ready));

	// One converter per mode, fed the same stream
	for (genvar g = 0; g < 4; g++) begin : g_dut
		csc_top #(.MODE(MODES[g])) i_dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
			.in_data(in_data), .in_ready(rdy[g]), .out_valid(ov[g]), .out_data(od[g]),
			.out_ready(out_ready));
	end

	// Collect every word handed downstream
	always @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++)
			if (ov[i] === 1'b1 && out_ready === 1'b1)
				got[i].push_back(od[i]);
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish();
		end
	end

	// Reference arithmetic: Q10 sums, round half up, clamp
	function automatic csc_pix_t ref_conv(input int m, input csc_pix_t p);
		int x [3];
		int s;
		int lo;
		csc_pix_t r;
		for (int k = 0; k < 3; k++) begin
			x[k] = (m == 3 && k > 0) ? int'($signed(p[k])) : int'(p[k]);
			if (m == 1)
				x[k] -= (k > 0) ? 128 : 16;
		end
		for (int j = 0; j < 3; j++) begin
			s = COEF[m][3*j]*x[0] + COEF[m][3*j+1]*x[1] + COEF[m][3*j+2]*x[2] + 512;
			if (m == 0)
				s += (j > 0) ? 131072 : 16384;
			s = s >>> 10;
			lo = (m == 2 && j > 0) ? -128 : 0;
			s = (s < lo) ? lo : (s > lo + 255) ? lo + 255 : s;
			r[j] = s[7:0];
		end
		return r;
	endfunction : ref_conv

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Offer one word and hold it until taken
	task automatic send(input csc_pix_t p);
		in_valid = 1'b1;
		in_data = p;
		while (rdy !== 4'hf) begin
			stalls++;
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
	endtask : send

	task automatic t_latency();
		send(PIX[4]);
		in_valid = 1'b0;
		@(negedge clk_sys);
		chk(ov, 4'h0);
		@(negedge clk_sys);
		chk(ov, 4'hf);
		chk(od[1], 24'hffffff);
		@(negedge clk_sys);
		chk(ov, 4'h0);
		$display("t_latency done");
	endtask : t_latency

	task automatic t_stream(input logic pace);
		slow = pace;
		stalls = 0;
		for (int m = 0; m < 4; m++)
			got[m].delete();
		for (int i = 0; i < 10; i++)
			send(PIX[i]);
		in_valid = 1'b0;
		repeat (60) @(negedge clk_sys);
		for (int m = 0; m < 4; m++) begin
			chk(got[m].size(), 10);
			for (int i = 0; i < got[m].size() && i < 10; i++)
				chk(got[m][i], ref_conv(m, PIX[i]));
		end
		chk(pace ? (stalls != 0) : (stalls == 0), 1);
		$display("t_stream done, slow %0d", pace);
	endtask : t_stream

	task automatic t_reset();
		slow = 1'b1;
		in_valid = 1'b1;
		in_data = PIX[0];
		repeat (8) @(negedge clk_sys);
		rst = 1'b1;
		in_valid = 1'b0;
		@(negedge clk_sys);
		chk(ov, 4'h0);
		rst = 1'b0;
		slow = 1'b0;
		@(negedge clk_sys);
		chk(rdy, 4'hf);
		$display("t_reset done");
	endtask : t_reset

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		rst = 1'b1;
		in_valid = 1'b0;
		in_data = '0;
		slow = 1'b0;
		errors = 0;
		tests_run = 0;
		cyc = 0;
		stalls = 0;
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		t_latency();
		t_stream(1'b0);
		t_stream(1'b1);
		t_reset();
		tally_and_finish();
	end
endmodule : tb_top
